// ### hdl/gpio_port_defines.vh
// Constants for the packet commanded pin port: register map, packet codes,
// field positions, reset configurations and timing counts.
// Assumes a 250 MHz system clock and a 32-bit APB register bus.
// Operation
// - Index 0-4 two-way, 5-12 output only.
// - Set command 0x22 takes two or three bytes.
// - Level 0 low, 1-99 PWM, 100 high.
// - Config byte: mode bits, function bit, rest zero.
// - Modes 000, 001, 010, 011 drive as listed.
// - Modes 100, 101, 111 as listed; 110 unused.
// - Function bit 0 alternate, 1 user; outputs ignore.
// - Pins 2-4 default to power, reset, one-wire.
// - Two-way pins sampled at 32 Hz continuously.
// - Edge latches per pin, cleared by query answer.
// - Read command 0x23 carries one index byte.
// - Read answer: index, state, level, config bytes.
// - State byte: level, falling, rising; outputs zero.
// - Reported level is the real sampled pin.
// - Pulses between samples go unseen entirely.
// - Level byte returns stored duty, not measurement.
// - Config reserved bits zero; output pins function zero.
// - Pin configuration is part of boot state.
// - Answer type is command code with 0x40.
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH

`define REG_CMD          8'h00
`define REG_CMD_DATA     8'h04
`define REG_RSP          8'h08
`define REG_RSP_DATA     8'h0C
`define REG_BOOT         8'h10
`define REG_LEVELS       8'h14

`define CMD_SET_PIN      8'h22
`define CMD_READ_PIN     8'h23
`define RSP_ACK_FLAG     8'h40
`define RSP_ERR_FLAG     8'h80

`define CMD_TYPE_LSB     0
`define CMD_LEN_LSB      8
`define RSP_LEN_LSB      8
`define RSP_VALID_BIT    16
`define RSP_ERR_BIT      17
`define BOOT_STORE_BIT   0
`define BOOT_LOAD_BIT    1

`define PIN_COUNT        13
`define GPIO_COUNT       5
`define DUTY_HIGH        7'h64
`define CFG_VALID_MAX    8'h0F
`define FUNC_BIT         3

`define CFG_RST_PIN0     4'h2
`define CFG_RST_SENSE    4'h3
`define CFG_RST_PWR_CTL  4'h2
`define CFG_RST_RESET    4'h2
`define CFG_RST_ONE_WIRE 4'h7
`define CFG_RST_LED      4'h1

`define CLK_HZ           250000000
`define SAMPLE_HZ        32
`define PWM_HZ           100
`define PWM_STEPS        100
`define SAMPLE_DIV       23'h773594 // CLK_HZ / SAMPLE_HZ, sized for its parameter.
`define PWM_STEP_DIV     15'h61A8   // CLK_HZ / (PWM_HZ * PWM_STEPS), sized likewise.

`endif

// ### hdl/packet_gpio_pwm_port.v
// Packet commanded port of five two-way pins and eight output-only LED pins.
// Software writes a command over APB, the port executes it on the write
// and leaves an answer packet in the answer registers.
// Assumes PIN_IN is asynchronous and ALT_LEVEL_IN comes from same-clock logic.
`timescale 1ns/1ps
`include "gpio_port_defines.vh"

module packet_gpio_pwm_port #(
    parameter [22:0] SAMPLE_DIV   = `SAMPLE_DIV,
    parameter [14:0] PWM_STEP_DIV = `PWM_STEP_DIV
) (
    // Clock and reset
    input  wire        CLOCK_IN,
    input  wire        RST_IN,
    // APB slave
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [7:0]  PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output reg  [31:0] PRDATA_OUT,
    output wire        PREADY_OUT,
    output wire        PSLVERR_OUT,
    // Pins
    input  wire [4:0]  PIN_IN,
    output reg  [12:0] PIN_OUT,
    output reg  [12:0] PIN_OE_OUT,
    output reg  [12:0] PULL_UP_OUT,
    output reg  [12:0] PULL_DOWN_OUT,
    output reg  [12:0] SLOW_SLEW_OUT,
    // Default alternate functions
    input  wire [4:0]  ALT_LEVEL_IN,
    output wire [4:0]  PIN_LEVEL_OUT,
    output wire [4:0]  USER_FUNC_OUT
);

    // Returns {oe, out, pull_up, pull_down, slow} for a mode and a level.
    function [4:0] drive_decode;
        input [2:0] mode;
        input       level;
        begin
            case (mode)
                3'b000:  drive_decode = level ? 5'b11000 : 5'b00010;
                3'b001:  drive_decode = {1'b1, level, 3'b000};
                3'b010:  drive_decode = 5'b00000;
                3'b011:  drive_decode = level ? 5'b00100 : 5'b10000;
                3'b100:  drive_decode = level ? 5'b11001 : 5'b00000;
                3'b101:  drive_decode = {1'b1, level, 3'b001};
                3'b111:  drive_decode = level ? 5'b00000 : 5'b10001;
                default: drive_decode = 5'b00000;
            endcase
        end
    endfunction

    function [3:0] reset_cfg;
        input integer idx;
        begin
            case (idx)
                0:       reset_cfg = `CFG_RST_PIN0;
                1:       reset_cfg = `CFG_RST_SENSE;
                2:       reset_cfg = `CFG_RST_PWR_CTL;
                3:       reset_cfg = `CFG_RST_RESET;
                4:       reset_cfg = `CFG_RST_ONE_WIRE;
                default: reset_cfg = `CFG_RST_LED;
            endcase
        end
    endfunction

    wire        apb_write;
    wire        apb_setup;
    wire        addr_hit;
    wire        cmd_write;
    wire        boot_store;
    wire        boot_load;
    wire [7:0]  cmd_type;
    wire [1:0]  cmd_len;
    wire [7:0]  arg_index;
    wire [7:0]  arg_level;
    wire [7:0]  arg_cfg;
    wire        index_ok;
    wire        set_ok;
    wire        read_ok;
    wire        set_level_we;
    wire        set_cfg_we;
    wire [3:0]  sel;
    wire [38:0] state_flat;
    wire [90:0] duty_flat;
    wire [51:0] cfg_flat;
    wire [2:0]  sel_state;
    wire [6:0]  sel_duty;
    wire [3:0]  sel_cfg;
    wire [4:0]  sample_flat;

    reg  [23:0] cmd_data_reg;
    reg  [7:0]  rsp_type_reg;
    reg  [2:0]  rsp_len_reg;
    reg         rsp_valid_reg;
    reg         rsp_err_reg;
    reg  [31:0] rsp_data_reg;
    reg  [22:0] sample_cnt_reg;
    reg         sample_tick_reg;
    reg  [14:0] step_div_reg;
    reg  [6:0]  step_reg;
    reg  [31:0] rdata_next;

    // Zero wait states: every access completes in its first access cycle.
    assign PREADY_OUT  = 1'b1;
    assign apb_write   = PSEL_IN & PENABLE_IN & PWRITE_IN;
    assign apb_setup   = PSEL_IN & ~PENABLE_IN;
    assign addr_hit    = (PADDR_IN == `REG_CMD) | (PADDR_IN == `REG_CMD_DATA) |
                         (PADDR_IN == `REG_RSP) | (PADDR_IN == `REG_RSP_DATA) |
                         (PADDR_IN == `REG_BOOT) | (PADDR_IN == `REG_LEVELS);
    assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_hit;

    assign cmd_write  = apb_write & (PADDR_IN == `REG_CMD);
    assign boot_store = apb_write & (PADDR_IN == `REG_BOOT) & PWDATA_IN[`BOOT_STORE_BIT];
    assign boot_load  = apb_write & (PADDR_IN == `REG_BOOT) & PWDATA_IN[`BOOT_LOAD_BIT];
    assign cmd_type   = PWDATA_IN[`CMD_TYPE_LSB +: 8];
    assign cmd_len    = PWDATA_IN[`CMD_LEN_LSB +: 2];
    assign arg_index  = cmd_data_reg[7:0];
    assign arg_level  = cmd_data_reg[15:8];
    assign arg_cfg    = cmd_data_reg[23:16];

    assign index_ok = (arg_index < `PIN_COUNT);
    assign set_ok   = (cmd_type == `CMD_SET_PIN) & index_ok &
                      ((cmd_len == 2'd2) | (cmd_len == 2'd3)) &
                      (arg_level <= {1'b0, `DUTY_HIGH}) &
                      ((cmd_len == 2'd2) | (arg_cfg <= `CFG_VALID_MAX));
    assign read_ok  = (cmd_type == `CMD_READ_PIN) & (cmd_len == 2'd1) &
                      index_ok;
    assign set_level_we = cmd_write & set_ok;
    assign set_cfg_we   = set_level_we & (cmd_len == 2'd3);
    assign sel          = arg_index[3:0];

    // Command arguments are staged before the command word is written.
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cmd_data_reg <= 24'h000000;
        end else if (apb_write & (PADDR_IN == `REG_CMD_DATA)) begin
            cmd_data_reg <= PWDATA_IN[23:0];
        end
    end

    // Common time bases: the 32 Hz sampling tick and the PWM step counter.
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sample_cnt_reg  <= 23'h000000;
            sample_tick_reg <= 1'b0;
            step_div_reg    <= 15'h0000;
            step_reg        <= 7'h00;
        end else begin
            sample_tick_reg <= (sample_cnt_reg == SAMPLE_DIV - 23'd1);
            if (sample_cnt_reg == SAMPLE_DIV - 23'd1) begin
                sample_cnt_reg <= 23'h000000;
            end else begin
                sample_cnt_reg <= sample_cnt_reg + 23'd1;
            end
            if (step_div_reg == PWM_STEP_DIV - 15'd1) begin
                step_div_reg <= 15'h0000;
                if (step_reg == `DUTY_HIGH - 7'd1) begin
                    step_reg <= 7'h00;
                end else begin
                    step_reg <= step_reg + 7'd1;
                end
            end else begin
                step_div_reg <= step_div_reg + 15'd1;
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < `PIN_COUNT; i = i + 1) begin : pin
            reg  [6:0] duty_reg;
            reg  [3:0] cfg_reg;
            reg  [6:0] boot_duty_reg;
            reg  [3:0] boot_cfg_reg;
            wire [2:0] pin_state;
            wire       pwm_level;
            wire       drive_level;
            wire [4:0] drive;
            wire       hit;

            assign hit       = (sel == i);
            // Duty 0 never matches and duty 100 always matches the step count.
            assign pwm_level = (step_reg < duty_reg);

            always @(posedge CLOCK_IN or posedge RST_IN) begin
                if (RST_IN) begin
                    duty_reg      <= 7'h00;
                    cfg_reg       <= reset_cfg(i);
                    boot_duty_reg <= 7'h00;
                    boot_cfg_reg  <= reset_cfg(i);
                end else begin
                    if (boot_load) begin
                        duty_reg <= boot_duty_reg;
                        cfg_reg  <= boot_cfg_reg;
                    end else begin
                        if (set_level_we & hit) begin
                            duty_reg <= arg_level[6:0];
                        end
                        if (set_cfg_we & hit) begin
                            // Output-only pins keep their function bit at zero.
                            cfg_reg <= {arg_cfg[`FUNC_BIT] & (i < `GPIO_COUNT),
                                        arg_cfg[2:0]};
                        end
                    end
                    if (boot_store) begin
                        boot_duty_reg <= duty_reg;
                        boot_cfg_reg  <= cfg_reg;
                    end
                end
            end

            if (i < `GPIO_COUNT) begin : io
                reg sync1_reg;
                reg sync2_reg;
                reg sync3_reg;
                reg stable_reg;
                reg sample_reg;
                reg rise_reg;
                reg fall_reg;
                wire clear;
                wire rise_event;
                wire fall_event;

                assign clear      = cmd_write & read_ok & hit;
                assign rise_event = sample_tick_reg & ~sample_reg & stable_reg;
                assign fall_event = sample_tick_reg & sample_reg & ~stable_reg;

                // A change is taken only once the second and third stage agree.
                always @(posedge CLOCK_IN or posedge RST_IN) begin
                    if (RST_IN) begin
                        sync1_reg  <= 1'b0;
                        sync2_reg  <= 1'b0;
                        sync3_reg  <= 1'b0;
                        stable_reg <= 1'b0;
                        sample_reg <= 1'b0;
                        rise_reg   <= 1'b0;
                        fall_reg   <= 1'b0;
                    end else begin
                        sync1_reg <= PIN_IN[i];
                        sync2_reg <= sync1_reg;
                        sync3_reg <= sync2_reg;
                        if (sync2_reg == sync3_reg) begin
                            stable_reg <= sync3_reg;
                        end
                        // Only the level at each tick is seen, so short pulses vanish.
                        if (sample_tick_reg) begin
                            sample_reg <= stable_reg;
                        end
                        // A new edge in the clearing cycle survives the clear.
                        rise_reg <= (rise_reg & ~clear) | rise_event;
                        fall_reg <= (fall_reg & ~clear) | fall_event;
                    end
                end

                assign pin_state        = {rise_reg, fall_reg, sample_reg};
                assign sample_flat[i]   = sample_reg;
                // Function bit 0 hands the pin's level to the default function.
                assign drive_level      = cfg_reg[`FUNC_BIT] ? pwm_level
                                                             : ALT_LEVEL_IN[i];
                assign USER_FUNC_OUT[i] = cfg_reg[`FUNC_BIT];
            end else begin : out_only
                assign pin_state   = 3'b000;
                assign drive_level = pwm_level;
            end

            assign drive = drive_decode(cfg_reg[2:0], drive_level);

            always @(posedge CLOCK_IN or posedge RST_IN) begin
                if (RST_IN) begin
                    PIN_OE_OUT[i]    <= 1'b0;
                    PIN_OUT[i]       <= 1'b0;
                    PULL_UP_OUT[i]   <= 1'b0;
                    PULL_DOWN_OUT[i] <= 1'b0;
                    SLOW_SLEW_OUT[i] <= 1'b0;
                end else begin
                    PIN_OE_OUT[i]    <= drive[4];
                    PIN_OUT[i]       <= drive[3];
                    PULL_UP_OUT[i]   <= drive[2];
                    PULL_DOWN_OUT[i] <= drive[1];
                    SLOW_SLEW_OUT[i] <= drive[0];
                end
            end

            assign state_flat[i*3 +: 3] = pin_state;
            assign duty_flat[i*7 +: 7]  = duty_reg;
            assign cfg_flat[i*4 +: 4]   = cfg_reg;
        end
    endgenerate

    assign PIN_LEVEL_OUT = sample_flat;
    assign sel_state     = index_ok ? state_flat[sel*3 +: 3] : 3'b000;
    assign sel_duty      = index_ok ? duty_flat[sel*7 +: 7] : 7'h00;
    assign sel_cfg       = index_ok ? cfg_flat[sel*4 +: 4] : 4'h0;

    // Every command word gets an answer; a refused one carries the error mark.
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rsp_type_reg  <= 8'h00;
            rsp_len_reg   <= 3'h0;
            rsp_valid_reg <= 1'b0;
            rsp_err_reg   <= 1'b0;
            rsp_data_reg  <= 32'h00000000;
        end else if (cmd_write) begin
            rsp_valid_reg <= 1'b1;
            if (set_ok) begin
                rsp_type_reg <= cmd_type | `RSP_ACK_FLAG;
                rsp_len_reg  <= 3'h0;
                rsp_err_reg  <= 1'b0;
                rsp_data_reg <= 32'h00000000;
            end else if (read_ok) begin
                rsp_type_reg <= cmd_type | `RSP_ACK_FLAG;
                rsp_len_reg  <= 3'h4;
                rsp_err_reg  <= 1'b0;
                rsp_data_reg <= {4'h0, sel_cfg,
                                 1'b0, sel_duty,
                                 5'h00, sel_state,
                                 arg_index};
            end else begin
                rsp_type_reg <= cmd_type | `RSP_ERR_FLAG;
                rsp_len_reg  <= 3'h0;
                rsp_err_reg  <= 1'b1;
                rsp_data_reg <= 32'h00000000;
            end
        end
    end

    always @* begin
        case (PADDR_IN)
            `REG_CMD_DATA: rdata_next = {8'h00, cmd_data_reg};
            `REG_RSP:      rdata_next = {14'h0000, rsp_err_reg, rsp_valid_reg,
                                         5'h00, rsp_len_reg, rsp_type_reg};
            `REG_RSP_DATA: rdata_next = rsp_data_reg;
            `REG_LEVELS:   rdata_next = {27'h0000000, sample_flat};
            default:       rdata_next = 32'h00000000;
        endcase
    end

    // Read data is captured in the setup cycle so it stands in a flop for the access.
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PRDATA_OUT <= 32'h00000000;
        end else if (apb_setup) begin
            PRDATA_OUT <= PWRITE_IN ? 32'h00000000 : rdata_next;
        end
    end

endmodule // packet_gpio_pwm_port

// ### bench/pin_load_model.sv
// Load on the five two-way pins: design drive, pulls and an outside source.
// Assumes the outside source is enabled only on undriven pins.
`timescale 1ns/1ps
module pin_load_model (
    input  wire       clk_in,
    input  wire [4:0] drive_level, drive_en, pull_up, pull_down, ext_en, ext_level,
    output reg  [4:0] pad_level
);
    reg [4:0] float_reg = 5'h15;
    integer   p;
    // An undriven, unpulled pad has no level, so it flips every cycle.
    always @(posedge clk_in)
        float_reg <= ~float_reg;
    always @* begin
        for (p = 0; p < 5; p = p + 1) begin
            if (ext_en[p])
                pad_level[p] = ext_level[p];
            else if (drive_en[p])
                pad_level[p] = drive_level[p];
            else if (pull_up[p] | pull_down[p])
                pad_level[p] = pull_up[p];
            else
                pad_level[p] = float_reg[p];
        end
    end
endmodule // pin_load_model

// ### bench/packet_gpio_pwm_port_asserts.sv
// Checker for the pin port: APB answers, drive exclusivity, sampling spacing.
// Assumes it is bound to the port and sees only its ports.
`timescale 1ns/1ps
`include "gpio_port_defines.vh"
module packet_gpio_pwm_port_checker #(
    parameter [22:0] SAMPLE_DIV = 23'h10
) (
    input wire        CLOCK_IN, RST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN,
    input wire [7:0]  PADDR_IN,
    input wire [31:0] PRDATA_OUT,
    input wire        PSLVERR_OUT,
    input wire [12:0] PIN_OE_OUT, PULL_UP_OUT, PULL_DOWN_OUT,
    input wire [4:0]  PIN_LEVEL_OUT, USER_FUNC_OUT
);
    reg  [22:0] gap_reg;
    reg  [4:0]  prev_reg;
    wire        cfg_wr = PSEL_IN && PENABLE_IN && PWRITE_IN &&
                         (PADDR_IN == `REG_CMD || PADDR_IN == `REG_BOOT);
    // Cycles since the sample last moved; an earlier move means an early tick.
    always @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN)
            gap_reg <= SAMPLE_DIV;
        else if (PIN_LEVEL_OUT != prev_reg)
            gap_reg <= 23'h0;
        else if (gap_reg != SAMPLE_DIV)
            gap_reg <= gap_reg + 23'h1;
    end
    always @(posedge CLOCK_IN)
        prev_reg <= PIN_LEVEL_OUT;
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    sequence s_setup_rd;
        PSEL_IN && !PENABLE_IN && !PWRITE_IN;
    endsequence
    sequence s_access;
        PSEL_IN && PENABLE_IN;
    endsequence
    property p_unmapped_err;
        (PSEL_IN && PENABLE_IN && PADDR_IN > `REG_LEVELS) |-> PSLVERR_OUT;
    endproperty
    property p_err_in_access;
        PSLVERR_OUT |-> s_access;
    endproperty
    property p_wo_reads_zero;
        s_setup_rd ##0 (PADDR_IN == `REG_CMD || PADDR_IN == `REG_BOOT) |=> PRDATA_OUT == 32'h0;
    endproperty
    property p_levels_read;
        s_setup_rd ##0 (PADDR_IN == `REG_LEVELS) |=> PRDATA_OUT[4:0] == $past(PIN_LEVEL_OUT);
    endproperty
    property p_rdata_holds;
        s_access |=> $stable(PRDATA_OUT);
    endproperty
    property p_drive_excl;
        ((PIN_OE_OUT & (PULL_UP_OUT | PULL_DOWN_OUT)) | (PULL_UP_OUT & PULL_DOWN_OUT)) == 13'h0;
    endproperty
    property p_sample_gap;
        (PIN_LEVEL_OUT != prev_reg) |-> gap_reg >= SAMPLE_DIV - 23'h1;
    endproperty
    property p_func_change;
        !$stable(USER_FUNC_OUT) |-> $past(cfg_wr) || $past(cfg_wr, 2);
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access without error");
    a_err_in_access: assert property (p_err_in_access)
        else $error("error outside access cycle");
    a_wo_reads_zero: assert property (p_wo_reads_zero)
        else $error("write-only register read nonzero");
    a_levels_read: assert property (p_levels_read)
        else $error("levels register differs from sample");
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read data moved after access");
    a_drive_excl: assert property (p_drive_excl)
        else $error("drive and pull on together");
    a_sample_gap: assert property (p_sample_gap)
        else $error("sample moved before a full period");
    a_func_change: assert property (p_func_change)
        else $error("function bit moved without a command");
endmodule // packet_gpio_pwm_port_checker
bind packet_gpio_pwm_port packet_gpio_pwm_port_checker #(.SAMPLE_DIV(SAMPLE_DIV)) chk (
    .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .PIN_OE_OUT(PIN_OE_OUT), .PULL_UP_OUT(PULL_UP_OUT),
    .PULL_DOWN_OUT(PULL_DOWN_OUT), .PIN_LEVEL_OUT(PIN_LEVEL_OUT), .USER_FUNC_OUT(USER_FUNC_OUT));

// ### bench/packet_gpio_pwm_port_test.sv
// Self-checking bench: random and corner pin commands over APB.
// Assumes the pin load model closes the loop from the drive outputs to PIN_IN.
`timescale 1ns/1ps
`include "gpio_port_defines.vh"
module packet_gpio_pwm_port_test;
    reg         clk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [7:0]  paddr = 8'h00, ri, rl, rc, exp_duty [0:12], exp_cfg [0:12];
    reg  [31:0] pwdata = 32'h0, rd;
    reg  [4:0]  alt = 5'h00, ext_en = 5'h00, ext_lvl = 5'h00;
    wire [31:0] prdata;
    wire        pready, pslverr;
    wire [4:0]  pad, lvl, ufunc;
    wire [12:0] pout, poe, ppu, ppd, pslow;
    integer     err_count = 0, n_tests = 0, seed = 32'h5d5d8ca9, i, j, k;
    always #2 clk_in = ~clk_in;
    packet_gpio_pwm_port #(.SAMPLE_DIV(23'h10), .PWM_STEP_DIV(15'h4)) uut (
        .CLOCK_IN(clk_in), .RST_IN(rst_in), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PIN_IN(pad), .PIN_OUT(pout),
        .PIN_OE_OUT(poe), .PULL_UP_OUT(ppu), .PULL_DOWN_OUT(ppd), .SLOW_SLEW_OUT(pslow),
        .ALT_LEVEL_IN(alt), .PIN_LEVEL_OUT(lvl), .USER_FUNC_OUT(ufunc));
    pin_load_model load (.clk_in(clk_in), .drive_level(pout[4:0]), .drive_en(poe[4:0]),
        .pull_up(ppu[4:0]), .pull_down(ppd[4:0]), .ext_en(ext_en), .ext_level(ext_lvl),
        .pad_level(pad));
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task fail_wait;
        err_count = err_count + 1;
        report_and_stop;
    endtask
    task check_reg(input string name, input [31:0] exp, input [31:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task check_pin(input string name, input [4:0] exp, input [4:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // The access phase is held until pready is seen high.
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        @(posedge clk_in);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk_in);
            n = n + 1;
        end
        if (pready !== 1'b1)
            fail_wait;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task set_pin(input [7:0] idx, input [7:0] lv, input [7:0] cf, input [1:0] len);
        reg ok;
        ok = idx < 13 && lv <= 100 && (len == 2 || (len == 3 && cf <= 15));
        apb(1'b1, `REG_CMD_DATA, {8'h00, cf, lv, idx});
        apb(1'b1, `REG_CMD, {22'h0, len, `CMD_SET_PIN});
        apb(1'b0, `REG_RSP, 32'h0);
        if (ok)
            check_reg("set answer", 32'h00010062, rd);
        else
            check_reg("set refusal", 32'h000300A2, rd);
        if (ok)
            exp_duty[idx] = lv;
        if (ok && len == 3)
            exp_cfg[idx] = idx < 5 ? cf : cf & 8'h07;
    endtask
    task rd_pin(input [7:0] idx, input chk, input [7:0] st);
        apb(1'b1, `REG_CMD_DATA, {24'h0, idx});
        apb(1'b1, `REG_CMD, {22'h0, 2'h1, `CMD_READ_PIN});
        apb(1'b0, `REG_RSP, 32'h0);
        check_reg("read answer", 32'h00010463, rd);
        apb(1'b0, `REG_RSP_DATA, 32'h0);
        if (!chk)
            rd[15:8] = st;
        check_reg("pin readback", {exp_cfg[idx], exp_duty[idx], st, idx}, rd);
    endtask
    function [4:0] drv(input [2:0] m, input l);
        case (m)
            3'h0: drv = l ? 5'h11 : 5'h04;
            3'h1: drv = l ? 5'h11 : 5'h10;
            3'h3: drv = l ? 5'h08 : 5'h10;
            3'h4: drv = l ? 5'h13 : 5'h00;
            3'h5: drv = l ? 5'h13 : 5'h12;
            3'h7: drv = l ? 5'h00 : 5'h12;
            default: drv = 5'h00;
        endcase
    endfunction
    initial #200000 fail_wait;
    initial begin
        for (i = 0; i < 13; i = i + 1) begin
            exp_duty[i] = 8'h00;
            exp_cfg[i] = i == 1 ? 8'h03 : i == 4 ? 8'h07 : i < 5 ? 8'h02 : 8'h01;
        end
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        for (i = 0; i < 13; i = i + 1)
            rd_pin(i[7:0], i > 4, 8'h00);
        apb(1'b0, 8'h20, 32'h0);
        check_reg("unmapped read", 32'h0, rd);
        $display("defaults done");
        set_pin(8'h0D, 8'h00, 8'h00, 2'h3);
        set_pin(8'h00, 8'h65, 8'h08, 2'h3);
        set_pin(8'h00, 8'h05, 8'h10, 2'h3);
        set_pin(8'h00, 8'h05, 8'h08, 2'h1);
        set_pin(8'h0C, 8'h64, 8'h0F, 2'h3);
        set_pin(8'h05, 8'h07, 8'h08, 2'h2);
        for (i = 0; i < 24; i = i + 1) begin
            alt <= $random(seed);
            ri = 8'({$random(seed)} % 14);
            rl = 8'({$random(seed)} % 102);
            rc = 8'({$random(seed)} % 17);
            if (rc[2:0] == 3'h6) rc = rc + 8'h01;
            set_pin(ri, rl, rc, 2'(2 + {$random(seed)} % 2));
            if (ri < 13)
                rd_pin(ri, ri > 4, 8'h00);
        end
        $display("set commands done");
        for (j = 0; j < 16; j = j + (j == 11 ? 3 : 1)) begin
            set_pin(8'h00, j[0] ? 8'h64 : 8'h00, 8'(8 + j / 2), 2'h3);
            repeat (2) @(posedge clk_in);
            check_pin("drive", drv(3'(j / 2), j[0]),
                {poe[0], ppu[0], ppd[0], pslow[0] & poe[0], pout[0] & poe[0]});
        end
        check_pin("user function", 5'h01, {4'h0, ufunc[0]});
        set_pin(8'h00, 8'h00, 8'h01, 2'h3);
        for (k = 0; k < 2; k = k + 1) begin
            alt <= {4'h0, k[0]};
            repeat (3) @(posedge clk_in);
            check_pin("alternate drive", drv(3'h1, k[0]),
                {poe[0], ppu[0], ppd[0], pslow[0] & poe[0], pout[0] & poe[0]});
        end
        check_pin("default function", 5'h00, {4'h0, ufunc[0]});
        $display("drive modes done");
        set_pin(8'h00, 8'h00, 8'h0A, 2'h3);
        ext_en <= 5'h01;
        ext_lvl <= 5'h00;
        repeat (48) @(posedge clk_in);
        rd_pin(8'h00, 1'b0, 8'h00);
        ext_lvl <= 5'h01;
        repeat (48) @(posedge clk_in);
        ext_lvl <= 5'h00;
        repeat (48) @(posedge clk_in);
        rd_pin(8'h00, 1'b1, 8'h06);
        rd_pin(8'h00, 1'b1, 8'h00);
        ext_lvl <= 5'h01;
        k = 0;
        while (lvl[0] !== 1'b1 && k < 100) begin
            @(posedge clk_in);
            k = k + 1;
        end
        if (k == 100)
            fail_wait;
        // The dip starts just after a sample tick.
        ext_lvl <= 5'h00;
        repeat (3) @(posedge clk_in);
        ext_lvl <= 5'h01;
        repeat (48) @(posedge clk_in);
        rd_pin(8'h00, 1'b1, 8'h05);
        apb(1'b0, `REG_LEVELS, 32'h0);
        check_reg("sampled level", 32'h1, {31'h0, rd[0]});
        $display("sampling done");
        for (i = 0; i < 5; i = i + 1) begin
            j = i == 0 ? 0 : i == 1 ? 1 : i == 2 ? 25 : i == 3 ? 99 : 100;
            set_pin(8'h05, j[7:0], 8'h01, 2'h3);
            repeat (8) @(posedge clk_in);
            k = 0;
            repeat (400) begin
                @(posedge clk_in);
                if (pout[5] === 1'b1)
                    k = k + 1;
            end
            check_reg("pwm high cycles", j * 4, k);
        end
        $display("pwm done");
        set_pin(8'h07, 8'h28, 8'h02, 2'h3);
        apb(1'b1, `REG_BOOT, 32'h1);
        set_pin(8'h07, 8'h28, 8'h05, 2'h3);
        apb(1'b1, `REG_BOOT, 32'h2);
        exp_cfg[7] = 8'h02;
        rd_pin(8'h07, 1'b1, 8'h00);
        apb(1'b0, `REG_BOOT, 32'h0);
        check_reg("boot reads zero", 32'h0, rd);
        $display("boot state done");
        report_and_stop;
    end
endmodule // packet_gpio_pwm_port_test
